//--- hw/afr_read_port.sv
`timescale 1ns/100ps
// Behaviour
// - level code 000 on underrun, 111 on overrun; both are errors.
// - code 010 reports almost empty, 32 words held.
// - code 101 reports almost full, 992 words held.
// - codes 001 empty, 011 ready, 100 half full, 110 full.
// - select high shows luma status, low shows chroma status.
// - read word comes from luma when select high, chroma when low.
// - read word bit 9 is msb, bit 0 lsb.
// - a read clock rising edge advances the selected fifo unless the output buffer holds two words and is stalled.
// - output enable low: word and code actively driven.
// - output enable high: word and code released to high impedance.
// - reads still advance while outputs are released.
// - pointer advances only while read enable low.
// - fifo reset low returns all pointers to start.
module afr_read_port #(
  parameter int unsigned DEPTH = afr_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic                       fifo_reset_n,
  input  wire logic                       luma_wr_valid,
  input  wire logic [afr_pkg::WORD_W-1:0] luma_wr_word,
  input  wire logic                       chroma_wr_valid,
  input  wire logic [afr_pkg::WORD_W-1:0] chroma_wr_word,
  input  wire logic                       read_clk,
  input  wire logic                       read_enable_n,
  input  wire logic                       luma_chroma_select,
  input  wire logic                       fifo_output_enable_n,
  input  wire logic                       out_ready,
  output logic      [afr_pkg::WORD_W-1:0] anc_read_word,
  output logic      [afr_pkg::WORD_W-1:0] anc_read_word_oe,
  output logic                            anc_read_valid,
  output logic      [2:0]                 fifo_level_code,
  output logic      [2:0]                 fifo_level_code_oe
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic rclk_s, ren_n_s, sel_s, oen_n_s;

  afr_sync3 u_sync_rclk (.clk_sys(clk_sys), .arst_n(arst_n), .din(read_clk),     .dout(rclk_s));
  afr_sync3 u_sync_ren  (.clk_sys(clk_sys), .arst_n(arst_n), .din(read_enable_n), .dout(ren_n_s));
  afr_sync3 u_sync_sel  (.clk_sys(clk_sys), .arst_n(arst_n), .din(luma_chroma_select),
                         .dout(sel_s));
  afr_sync3 u_sync_oen  (.clk_sys(clk_sys), .arst_n(arst_n), .din(fifo_output_enable_n),
                         .dout(oen_n_s));

  // ------------------------------------------------------------
  // read strobe from read clock edges
  // ------------------------------------------------------------
  logic rclk_d_reg, rclk_d_next;
  logic rd_strobe;
  logic buf_ready;

  always_comb begin
    rclk_d_next = rclk_s;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) rclk_d_reg <= 1'b0;
    else rclk_d_reg <= rclk_d_next;
  end

  // output enable state deliberately ignored here so hidden reads still consume
  assign rd_strobe = rclk_s && !rclk_d_reg && !ren_n_s && buf_ready;

  // ------------------------------------------------------------
  // fifo pair
  // ------------------------------------------------------------
  logic                       clr;
  logic [afr_pkg::WORD_W-1:0] y_word, c_word;
  logic                       y_ok, c_ok;
  logic [2:0]                 y_code, c_code;

  assign clr = !fifo_reset_n;

  afr_channel #(.DEPTH(DEPTH)) u_luma (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .clear      (clr),
    .wr_req     (luma_wr_valid),
    .wr_word    (luma_wr_word),
    .rd_req     (rd_strobe && sel_s),
    .rd_word    (y_word),
    .rd_ok      (y_ok),
    .level_code (y_code)
  );

  afr_channel #(.DEPTH(DEPTH)) u_chroma (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .clear      (clr),
    .wr_req     (chroma_wr_valid),
    .wr_word    (chroma_wr_word),
    .rd_req     (rd_strobe && !sel_s),
    .rd_word    (c_word),
    .rd_ok      (c_ok),
    .level_code (c_code)
  );

  // ------------------------------------------------------------
  // two-entry output buffer
  // ------------------------------------------------------------
  logic [afr_pkg::WORD_W-1:0] b0_reg, b0_next, b1_reg, b1_next;
  logic [1:0]                 bcnt_reg, bcnt_next;
  logic                       in_v;
  logic [afr_pkg::WORD_W-1:0] in_w;
  logic                       pop;

  always_comb begin
    in_v = y_ok || c_ok;
    in_w = y_ok ? y_word : c_word;
    pop  = (bcnt_reg != 2'h0) && out_ready;
    b0_next   = b0_reg;
    b1_next   = b1_reg;
    bcnt_next = bcnt_reg;
    if (pop) begin
      b0_next   = b1_reg;
      bcnt_next = bcnt_reg - 2'h1;
    end
    if (in_v) begin
      if (bcnt_next == 2'h0) b0_next = in_w;
      else b1_next = in_w;
      bcnt_next = bcnt_next + 2'h1;
    end
    if (clr) bcnt_next = 2'h0;
  end

  // only strobe when a slot is free after this cycle's pop
  assign buf_ready = (bcnt_reg != 2'h2) || out_ready;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      b0_reg   <= '0;
      b1_reg   <= '0;
      bcnt_reg <= 2'h0;
    end else begin
      b0_reg   <= b0_next;
      b1_reg   <= b1_next;
      bcnt_reg <= bcnt_next;
    end
  end

  // ------------------------------------------------------------
  // pin outputs
  // ------------------------------------------------------------
  logic [2:0] code_reg, code_next;

  always_comb begin
    code_next = sel_s ? y_code : c_code;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) code_reg <= afr_pkg::CODE_EMPTY;
    else code_reg <= code_next;
  end

  assign anc_read_word      = b0_reg;
  assign anc_read_valid     = (bcnt_reg != 2'h0);
  assign fifo_level_code    = code_reg;
  assign anc_read_word_oe   = {afr_pkg::WORD_W{!oen_n_s}};
  assign fifo_level_code_oe = {3{!oen_n_s}};
endmodule : afr_read_port

//--- hw/afr_pkg.sv
package afr_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int unsigned WORD_W     = 10;
  localparam int unsigned FIFO_DEPTH = 1024;
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned CNT_W      = 11;

  // ------------------------------------------------------------
  // fill thresholds, in words held
  // ------------------------------------------------------------
  localparam logic [10:0] ALMOST_EMPTY_LVL = 11'h020;
  localparam logic [10:0] ALMOST_FULL_LVL  = 11'h3E0;
  localparam logic [10:0] HALF_FULL_LVL    = 11'h200;
  localparam logic [10:0] FULL_LVL         = 11'h400;

  // ------------------------------------------------------------
  // level codes
  // ------------------------------------------------------------
  localparam logic [2:0] CODE_UNDERRUN     = 3'h0;
  localparam logic [2:0] CODE_EMPTY        = 3'h1;
  localparam logic [2:0] CODE_ALMOST_EMPTY = 3'h2;
  localparam logic [2:0] CODE_READY        = 3'h3;
  localparam logic [2:0] CODE_HALF_FULL    = 3'h4;
  localparam logic [2:0] CODE_ALMOST_FULL  = 3'h5;
  localparam logic [2:0] CODE_FULL         = 3'h6;
  localparam logic [2:0] CODE_OVERRUN      = 3'h7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [2:0] SYNC_RST = 3'h0;

endpackage : afr_pkg

//--- hw/afr_sync3.sv
`timescale 1ns/100ps
// three-stage synchroniser: output changes once stages two and three agree
module afr_sync3 (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       dout_reg;
  logic       dout_next;

  always_comb begin
    sync_next = {sync_reg[1:0], din};
    dout_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : dout_reg;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= afr_pkg::SYNC_RST;
      dout_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;
endmodule : afr_sync3

//--- hw/afr_channel.sv
`timescale 1ns/100ps
// one ancillary fifo with sticky under/overrun and level code
module afr_channel #(
  parameter int unsigned DEPTH = afr_pkg::FIFO_DEPTH
) (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic                      clear,
  input  wire logic                      wr_req,
  input  wire logic [afr_pkg::WORD_W-1:0] wr_word,
  input  wire logic                      rd_req,
  output logic      [afr_pkg::WORD_W-1:0] rd_word,
  output logic                           rd_ok,
  output logic      [2:0]                level_code
);
  if (DEPTH != afr_pkg::FIFO_DEPTH) begin : g_depth_check
    $error("afr_channel: depth must match pointer width");
  end

  logic [afr_pkg::WORD_W-1:0] mem [DEPTH];
  logic [afr_pkg::ADDR_W-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [afr_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  logic                       unr_reg, unr_next, ovr_reg, ovr_next;
  logic                       do_wr, do_rd;

  always_comb begin
    do_wr    = wr_req && (cnt_reg != afr_pkg::FULL_LVL);
    do_rd    = rd_req && (cnt_reg != '0);
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    unr_next = unr_reg | (rd_req && !do_rd);
    ovr_next = ovr_reg | (wr_req && !do_wr);
    if (do_wr) wp_next = wp_reg + 1'b1;
    if (do_rd) rp_next = rp_reg + 1'b1;
    case ({do_wr, do_rd})
      2'b10:   cnt_next = cnt_reg + 1'b1;
      2'b01:   cnt_next = cnt_reg - 1'b1;
      default: cnt_next = cnt_reg;
    endcase
    if (clear) begin
      wp_next  = '0;
      rp_next  = '0;
      cnt_next = '0;
      unr_next = 1'b0;
      ovr_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
      unr_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
      unr_reg <= unr_next;
      ovr_reg <= ovr_next;
    end
  end

  // memory has no reset so it can map to ram
  always_ff @(posedge clk_sys) begin
    if (do_wr && !clear) mem[wp_reg] <= wr_word;
  end

  assign rd_word = mem[rp_reg];
  assign rd_ok   = do_rd && !clear;

  always_comb begin
    if (ovr_reg) level_code = afr_pkg::CODE_OVERRUN;
    else if (unr_reg) level_code = afr_pkg::CODE_UNDERRUN;
    else if (cnt_reg == '0) level_code = afr_pkg::CODE_EMPTY;
    else if (cnt_reg == afr_pkg::FULL_LVL) level_code = afr_pkg::CODE_FULL;
    else if (cnt_reg >= afr_pkg::ALMOST_FULL_LVL) level_code = afr_pkg::CODE_ALMOST_FULL;
    else if (cnt_reg >= afr_pkg::HALF_FULL_LVL) level_code = afr_pkg::CODE_HALF_FULL;
    else if (cnt_reg > afr_pkg::ALMOST_EMPTY_LVL) level_code = afr_pkg::CODE_READY;
    else level_code = afr_pkg::CODE_ALMOST_EMPTY;
  end
endmodule : afr_channel

//--- tb/afr_read_port_sva.sv
`timescale 1ns/100ps
// ----------
// port checker
// ----------
module afr_read_port_sva #(
  parameter int unsigned DEPTH = afr_pkg::FIFO_DEPTH
) (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       fifo_reset_n,
  input wire logic       read_clk,
  input wire logic       read_enable_n,
  input wire logic       luma_chroma_select,
  input wire logic       fifo_output_enable_n,
  input wire logic       out_ready,
  input wire logic [9:0] anc_read_word,
  input wire logic [9:0] anc_read_word_oe,
  input wire logic       anc_read_valid,
  input wire logic [2:0] fifo_level_code,
  input wire logic [2:0] fifo_level_code_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // pins pass a 3-flop synchroniser plus output flop, so five samples are the minimum
  sequence s_en_on; (!fifo_output_enable_n)[*5]; endsequence
  sequence s_en_off; fifo_output_enable_n[*5]; endsequence
  sequence s_err; ($stable(luma_chroma_select) && fifo_reset_n)[*6]
    ##0 fifo_level_code == 3'h0; endsequence
  property p_oe_on; s_en_on |-> anc_read_word_oe == 10'h3FF && fifo_level_code_oe == 3'h7;
  endproperty
  property p_oe_off; s_en_off |-> anc_read_word_oe == 10'h000 && fifo_level_code_oe == 3'h0;
  endproperty
  property p_oe_pair; fifo_level_code_oe == {3{anc_read_word_oe[0]}}; endproperty
  property p_hold; anc_read_valid && !out_ready && fifo_reset_n
    |=> anc_read_valid && $stable(anc_read_word); endproperty
  property p_no_ren; (read_enable_n && !anc_read_valid)[*6] |=> !anc_read_valid; endproperty
  property p_idle; (!read_clk && !anc_read_valid)[*6] |=> !anc_read_valid; endproperty
  property p_frst; (!fifo_reset_n)[*4] |-> !anc_read_valid && fifo_level_code == 3'h1;
  endproperty
  property p_sticky; s_err |=> fifo_level_code inside {3'h0, 3'h7}; endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
  a_oe_off: assert property (p_oe_off) else $error("outputs not released");
  a_oe_pair: assert property (p_oe_pair) else $error("enables disagree");
  a_hold: assert property (p_hold) else $error("stalled word lost");
  a_no_ren: assert property (p_no_ren) else $error("read while disabled");
  a_idle: assert property (p_idle) else $error("read without edge");
  a_frst: assert property (p_frst) else $error("fifo reset ignored");
  a_sticky: assert property (p_sticky) else $error("underrun not held");
endmodule : afr_read_port_sva

//--- tb/afr_reader_model.sv
`timescale 1ns/100ps
// ----------
// external reader
// ----------
module afr_reader_model (
  output logic read_clk,
  output logic read_enable_n,
  output logic luma_chroma_select
);
  initial begin
    read_clk = 1'b0;
    read_enable_n = 1'b1;
    luma_chroma_select = 1'b1;
  end
  // read clock stands low between bursts; select held over all edges
  task automatic burst(input logic sel, input logic ren_n, input int n);
    luma_chroma_select = sel;
    read_enable_n = ren_n;
    // odd lead keeps every read clock edge off the system clock edges
    #61.3;
    repeat (n) begin
      read_clk = 1'b1;
      #62.5;
      read_clk = 1'b0;
      #62.5;
    end
    read_enable_n = 1'b1;
  endtask : burst
endmodule : afr_reader_model

//--- tb/test_afr_read_port.sv
`timescale 1ns/100ps
// ----------
// bench
// ----------
module test_afr_read_port;
  logic       clk_sys, arst_n, fifo_reset_n, luma_wr_valid, chroma_wr_valid;
  logic [9:0] luma_wr_word, chroma_wr_word, anc_read_word, anc_read_word_oe;
  logic [2:0] fifo_level_code, fifo_level_code_oe;
  logic       read_clk, read_enable_n, luma_chroma_select;
  logic       fifo_output_enable_n, out_ready, anc_read_valid;
  int         bad_count = 0, n_checks = 0, cycles = 0;
  logic [9:0] got_q[$];
  afr_read_port i_afr_read_port (.clk_sys, .arst_n, .fifo_reset_n, .luma_wr_valid,
    .luma_wr_word, .chroma_wr_valid, .chroma_wr_word, .read_clk, .read_enable_n,
    .luma_chroma_select, .fifo_output_enable_n, .out_ready, .anc_read_word,
    .anc_read_word_oe, .anc_read_valid, .fifo_level_code, .fifo_level_code_oe);
  afr_reader_model i_afr_reader_model (.read_clk, .read_enable_n, .luma_chroma_select);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (anc_read_valid === 1'b1 && out_ready === 1'b1) got_q.push_back(anc_read_word);
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic code_is(logic [2:0] e);
    repeat (4) @(negedge clk_sys);
    chk("level_code", {7'h00, e}, {7'h00, fifo_level_code});
  endtask : code_is
  task automatic wr(logic luma, int n, logic [9:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      luma_wr_valid = luma;
      chroma_wr_valid = !luma;
      luma_wr_word = 10'(base + i);
      chroma_wr_word = 10'(base + i);
    end
    @(negedge clk_sys);
    luma_wr_valid = 1'b0;
    chroma_wr_valid = 1'b0;
  endtask : wr
  task automatic fifo_rst();
    @(negedge clk_sys);
    fifo_reset_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    fifo_reset_n = 1'b1;
  endtask : fifo_rst
  task automatic t_levels();
    int         n_t[5] = '{32, 1, 479, 480, 32};
    logic [2:0] c_t[5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    i_afr_reader_model.burst(1'b1, 1'b1, 0);
    code_is(3'h1);
    for (int i = 0; i < 5; i++) begin
      wr(1'b1, n_t[i], 10'h000);
      code_is(c_t[i]);
    end
    i_afr_reader_model.burst(1'b0, 1'b1, 0);
    code_is(3'h1);
    i_afr_reader_model.burst(1'b1, 1'b1, 0);
    wr(1'b1, 1, 10'h000);
    code_is(3'h7);
    fifo_rst();
    code_is(3'h1);
  endtask : t_levels
  task automatic t_read();
    logic [9:0] exp_w[5] = '{10'h201, 10'h202, 10'h203, 10'h0FE, 10'h0FF};
    wr(1'b1, 3, 10'h201);
    wr(1'b0, 2, 10'h0FE);
    out_ready = 1'b0;
    // third edge meets a full buffer and is dropped
    i_afr_reader_model.burst(1'b1, 1'b0, 3);
    code_is(3'h2);
    chk("valid", 10'h001, {9'h000, anc_read_valid});
    out_ready = 1'b1;
    fifo_output_enable_n = 1'b1;
    code_is(3'h2);
    chk("word_oe", 10'h000, anc_read_word_oe);
    i_afr_reader_model.burst(1'b1, 1'b0, 1);
    @(negedge clk_sys);
    fifo_output_enable_n = 1'b0;
    i_afr_reader_model.burst(1'b1, 1'b1, 2);
    chk("word_oe", 10'h3FF, anc_read_word_oe);
    i_afr_reader_model.burst(1'b0, 1'b0, 2);
    i_afr_reader_model.burst(1'b1, 1'b0, 1);
    code_is(3'h0);
    chk("count", 10'h005, 10'(got_q.size()));
    foreach (exp_w[i]) chk("word", exp_w[i], got_q[i]);
  endtask : t_read
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    arst_n = 1'b0;
    fifo_reset_n = 1'b1;
    luma_wr_valid = 1'b0;
    chroma_wr_valid = 1'b0;
    luma_wr_word = 10'h000;
    chroma_wr_word = 10'h000;
    fifo_output_enable_n = 1'b0;
    out_ready = 1'b1;
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_levels();
    t_read();
    repeat (10) @(negedge clk_sys);
    tally_and_finish();
  end
endmodule : test_afr_read_port
bind afr_read_port afr_read_port_sva #(.DEPTH(DEPTH)) i_afr_read_port_sva (.clk_sys, .arst_n,
  .fifo_reset_n, .read_clk, .read_enable_n, .luma_chroma_select, .fifo_output_enable_n,
  .out_ready, .anc_read_word, .anc_read_word_oe, .anc_read_valid, .fifo_level_code,
  .fifo_level_code_oe);
